// ### include/pcrbm_defines.vh
// pcrbm_defines.vh: constants for the endpoint configuration reset and bar mask block
// assumes inclusion by the design files only; definitions, no logic
`ifndef PCRBM_DEFINES_VH
`define PCRBM_DEFINES_VH

// local command status register field: mask access enable
`define PCRBM_MASK_EN_BIT     5
// number of bar mask registers
`define PCRBM_NUM_BARS        6
// index of bar 5
`define PCRBM_BAR5_IDX        5
// bar mask reset value: zero means window disabled
`define PCRBM_MASK_RST        32'h0000_0000
// sticky and non-sticky reset values
`define PCRBM_STICKY_RST      32'h0000_0000
`define PCRBM_NSTICKY_RST     32'h0000_0000
// local register selects
`define PCRBM_SEL_CMD         4'h0
`define PCRBM_SEL_STICKY      4'h1
`define PCRBM_SEL_NSTICKY     4'h2
`define PCRBM_SEL_MASK0       4'h8

`endif

// ### logic/pcrbm_cfg_word.v
// pcrbm_cfg_word.v: one configuration word with a reset class
// assumes single clock, async active-low power-on reset, synchronous reset pulses
`timescale 1ns/10ps
`include "pcrbm_defines.vh"

module pcrbm_cfg_word #(
  parameter        WIDTH  = 32,
  parameter        STICKY = 0,
  parameter [31:0] RSTVAL = 32'h0000_0000
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_rst_n,
  // reset events
  input  wire             i_hot_rst,
  input  wire             i_soft_rst,
  input  wire             i_hard_rst,
  // write port
  input  wire             i_wr_en,
  input  wire [WIDTH-1:0] i_wr_data,
  // state
  output wire [WIDTH-1:0] o_value
);

  reg [WIDTH-1:0] word_ff;
  reg [WIDTH-1:0] nxt_word;
  reg             clr;

  // reset class decides which resets reach the word
  always @* begin
    clr = i_hard_rst;
    if (STICKY == 0) begin
      clr = clr | i_soft_rst | i_hot_rst;
    end
    nxt_word = word_ff;
    if (clr) begin
      nxt_word = RSTVAL[WIDTH-1:0];
    end else if (i_wr_en) begin
      nxt_word = i_wr_data;
    end
  end

  // sticky words ignore hot and soft reset, keeping error state
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_ff <= RSTVAL[WIDTH-1:0];
    end else begin
      word_ff <= nxt_word;
    end
  end

  assign o_value = word_ff;

endmodule

// ### logic/pcrbm_top.v
// pcrbm_top.v: endpoint configuration reset classes and gated bar mask programming
// assumes local bus and link bus are synchronous to i_mclk, one write per cycle each
// assumes hot, soft and hard reset arrive as one-cycle pulses from the port's reset logic
`timescale 1ns/10ps
`include "pcrbm_defines.vh"

module pcrbm_top #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_rst_n,
  // reset events, one-cycle pulses
  input  wire             i_hot_rst,
  input  wire             i_soft_rst,
  input  wire             i_hard_rst,
  // local side write/read
  input  wire             i_loc_wr,
  input  wire             i_loc_rd,
  input  wire [3:0]       i_loc_sel,
  input  wire [WIDTH-1:0] i_loc_wdata,
  output reg  [WIDTH-1:0] o_loc_rdata,
  output reg              o_loc_rvalid,
  // link side write, mask registers not reachable
  input  wire             i_lnk_wr,
  input  wire [3:0]       i_lnk_sel,
  input  wire [WIDTH-1:0] i_lnk_wdata,
  // state
  output reg              o_mask_access_enable_bit,
  output reg              o_bar5_enabled,
  output reg  [WIDTH-1:0] o_bar5_mask,
  output reg              o_mask_wr_dropped
);

  ////////////////////////////////////////////////////////////////////////
  // command status word, non-sticky
  // bit 5 opens the bar mask gate; both sides may write this word, and a
  // local write wins when both strike in the same cycle, so the processor
  // can always close the gate again even while the host is busy

  wire             cmd_wr;
  wire [WIDTH-1:0] cmd_wdata;
  wire [WIDTH-1:0] cmd_val;

  // write strobe and data for the command word from either side
  assign cmd_wr    = (i_loc_wr && i_loc_sel == `PCRBM_SEL_CMD) ||
                     (i_lnk_wr && i_lnk_sel == `PCRBM_SEL_CMD);
  assign cmd_wdata = (i_loc_wr && i_loc_sel == `PCRBM_SEL_CMD) ? i_loc_wdata : i_lnk_wdata;

  pcrbm_cfg_word #(.WIDTH(WIDTH), .STICKY(0), .RSTVAL(`PCRBM_NSTICKY_RST)) u_cmd (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_hot_rst  (i_hot_rst),
    .i_soft_rst (i_soft_rst),
    .i_hard_rst (i_hard_rst),
    .i_wr_en    (cmd_wr),
    .i_wr_data  (cmd_wdata),
    .o_value    (cmd_val)
  );

  ////////////////////////////////////////////////////////////////////////
  // example sticky (error status) and non-sticky words
  // the sticky word stands for error control and status: only a hard reset
  // or power-on clears it, so a host that retrains the link can still read
  // what went wrong before

  wire             stk_wr;
  wire             nst_wr;
  wire [WIDTH-1:0] stk_val;
  wire [WIDTH-1:0] nst_val;

  // only the local side reaches these two words
  assign stk_wr = i_loc_wr && i_loc_sel == `PCRBM_SEL_STICKY;
  assign nst_wr = i_loc_wr && i_loc_sel == `PCRBM_SEL_NSTICKY;

  pcrbm_cfg_word #(.WIDTH(WIDTH), .STICKY(1), .RSTVAL(`PCRBM_STICKY_RST)) u_stk (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_hot_rst  (i_hot_rst),
    .i_soft_rst (i_soft_rst),
    .i_hard_rst (i_hard_rst),
    .i_wr_en    (stk_wr),
    .i_wr_data  (i_loc_wdata),
    .o_value    (stk_val)
  );

  pcrbm_cfg_word #(.WIDTH(WIDTH), .STICKY(0), .RSTVAL(`PCRBM_NSTICKY_RST)) u_nst (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_hot_rst  (i_hot_rst),
    .i_soft_rst (i_soft_rst),
    .i_hard_rst (i_hard_rst),
    .i_wr_en    (nst_wr),
    .i_wr_data  (i_loc_wdata),
    .o_value    (nst_val)
  );

  ////////////////////////////////////////////////////////////////////////
  // bar mask registers: local side only, gated by mask enable
  // selects 8 to 13 reach masks 0 to 5; 14 and 15 are holes that read zero
  // the gate is the stored bit, not the write data, so a write that sets
  // bit 5 opens the gate from the following cycle only
  // masks are treated as non-sticky: any reset closes every window again

  wire             mask_en;
  wire             mask_sel;
  wire [2:0]       mask_idx;
  wire [WIDTH-1:0] mask_val [0:`PCRBM_NUM_BARS-1];

  // gate and select decode shared by every mask word
  assign mask_en  = cmd_val[`PCRBM_MASK_EN_BIT];
  assign mask_sel = i_loc_sel[3] && (i_loc_sel[2:0] < `PCRBM_NUM_BARS);
  assign mask_idx = i_loc_sel[2:0];

  genvar g;
  generate
    for (g = 0; g < `PCRBM_NUM_BARS; g = g + 1) begin : g_mask
      wire wr_g;
      // link writes never reach the masks
      // one word per bar; the strobe is the only thing that differs, so a
      // refused write leaves every mask untouched
      assign wr_g = i_loc_wr && mask_sel && mask_en && (mask_idx == g);
      pcrbm_cfg_word #(.WIDTH(WIDTH), .STICKY(0), .RSTVAL(`PCRBM_MASK_RST)) u_mask (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_hot_rst  (i_hot_rst),
        .i_soft_rst (i_soft_rst),
        .i_hard_rst (i_hard_rst),
        .i_wr_en    (wr_g),
        .i_wr_data  (i_loc_wdata),
        .o_value    (mask_val[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux, one cycle latency
  // holes and the two unused mask selects read zero, never an unknown

  reg [WIDTH-1:0] nxt_rdata;

  always @* begin
    nxt_rdata = {WIDTH{1'b0}};
    if (i_loc_sel == `PCRBM_SEL_CMD) begin
      nxt_rdata = cmd_val;
    end else if (i_loc_sel == `PCRBM_SEL_STICKY) begin
      nxt_rdata = stk_val;
    end else if (i_loc_sel == `PCRBM_SEL_NSTICKY) begin
      nxt_rdata = nst_val;
    end else if (mask_sel) begin
      nxt_rdata = mask_val[mask_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refused mask writes

  wire loc_mask_refused;
  wire lnk_mask_refused;

  // a local write to a mask select with the gate shut is dropped
  assign loc_mask_refused = i_loc_wr && mask_sel && !mask_en;
  // the link may never reach a mask, whatever the gate says; flagging it
  // lets local software notice a host that breaks the rule
  assign lnk_mask_refused = i_lnk_wr && i_lnk_sel[3];

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  // read port: data holds until the next read so slow software can
  // fetch it late; valid is a one-cycle pulse per strobe
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_loc_rdata  <= {WIDTH{1'b0}};
      o_loc_rvalid <= 1'b0;
    end else begin
      o_loc_rdata  <= i_loc_rd ? nxt_rdata : o_loc_rdata;
      o_loc_rvalid <= i_loc_rd;
    end
  end

  // gate mirror lags the stored bit by one cycle; software polling it
  // right after a write must allow for that
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mask_access_enable_bit <= 1'b0;
    end else begin
      o_mask_access_enable_bit <= mask_en;
    end
  end

  // bar5 view: window disabled while the mask is zero, so an endpoint
  // that was never programmed shows no size to the host
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bar5_enabled <= 1'b0;
      o_bar5_mask    <= {WIDTH{1'b0}};
    end else begin
      o_bar5_enabled <= |mask_val[`PCRBM_BAR5_IDX];
      o_bar5_mask    <= mask_val[`PCRBM_BAR5_IDX];
    end
  end

  // refusal pulse, one cycle per dropped write, a single one when both sides drop in one cycle; not sticky, so a burst
  // of refused writes shows as a run of pulses
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mask_wr_dropped <= 1'b0;
    end else begin
      o_mask_wr_dropped <= loc_mask_refused || lnk_mask_refused;
    end
  end

endmodule

// ### tb/pcrbm_properties.sv
// pcrbm_properties.sv: port assertions for pcrbm_top
// assumes one clock and the async active-low reset
`timescale 1ns/10ps
module pcrbm_checker #(parameter WIDTH = 32) (
  // watched ports
  input wire             i_mclk, i_rst_n, i_hot_rst, i_soft_rst, i_hard_rst,
  input wire             i_loc_wr, i_lnk_wr, o_mask_access_enable_bit,
  input wire             o_bar5_enabled, o_mask_wr_dropped,
  input wire [3:0]       i_loc_sel, i_lnk_sel,
  input wire [WIDTH-1:0] i_loc_wdata, o_bar5_mask
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_soft; i_soft_rst |-> ##2 o_bar5_mask == '0; endproperty
  a_soft: assert property (p_soft) else $error("soft reset kept mask");
  property p_hard;
    i_hard_rst |-> ##2 (o_bar5_mask == '0 && !o_mask_access_enable_bit);
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset kept state");
  property p_win; o_bar5_enabled == (o_bar5_mask != '0); endproperty
  a_win: assert property (p_win) else $error("window flag wrong");
  // enable output lags its register, so skip cycles right after any write
  property p_take;
    i_loc_wr && i_loc_sel == 4'hd && o_mask_access_enable_bit &&
      !(i_hot_rst | i_soft_rst | i_hard_rst) &&
      !$past(i_loc_wr | i_lnk_wr | i_hot_rst | i_soft_rst | i_hard_rst)
      |-> ##2 o_bar5_mask == $past(i_loc_wdata, 2);
  endproperty
  a_take: assert property (p_take) else $error("mask not taken");
  property p_lnk;
    i_lnk_wr && i_lnk_sel[3] && !i_loc_wr && !(i_hot_rst | i_soft_rst | i_hard_rst)
      |=> o_mask_wr_dropped ##1 $stable(o_bar5_mask);
  endproperty
  a_lnk: assert property (p_lnk) else $error("link mask write kept");
  property p_drop;
    i_loc_wr && i_loc_sel[3] && i_loc_sel[2:1] != 2'b11 && !o_mask_access_enable_bit &&
      !(i_hot_rst | i_soft_rst | i_hard_rst) && !$past(i_loc_wr | i_lnk_wr)
      |=> o_mask_wr_dropped ##1 $stable(o_bar5_mask);
  endproperty
  a_drop: assert property (p_drop) else $error("gated write kept");
endmodule
bind pcrbm_top pcrbm_checker #(.WIDTH(WIDTH)) u_pcrbm_checker (.i_mclk(i_mclk),
  .i_rst_n(i_rst_n), .i_hot_rst(i_hot_rst), .i_soft_rst(i_soft_rst),
  .i_hard_rst(i_hard_rst), .i_loc_wr(i_loc_wr), .i_lnk_wr(i_lnk_wr),
  .o_mask_access_enable_bit(o_mask_access_enable_bit), .o_bar5_enabled(o_bar5_enabled),
  .o_mask_wr_dropped(o_mask_wr_dropped), .i_loc_sel(i_loc_sel), .i_lnk_sel(i_lnk_sel),
  .i_loc_wdata(i_loc_wdata), .o_bar5_mask(o_bar5_mask));

// ### tb/pcrbm_link_model.sv
// pcrbm_link_model.sv: link partner issuing writes
// assumes the bench calls send between edges
`timescale 1ns/10ps
module pcrbm_link_model (
  // link write
  input  wire        i_mclk,
  output reg         o_wr = 1'b0,
  output reg  [3:0]  o_sel = 4'h0,
  output reg  [31:0] o_wdata = 32'h0
);
  // mask selects are sent only when a test wants the refusal
  task send(input [3:0] s, input [31:0] d);
    begin
      @(negedge i_mclk);
      o_wr = 1'b1;
      o_sel = s;
      o_wdata = d;
      @(negedge i_mclk);
      o_wr = 1'b0;
      o_wdata = ~d; // released bus shows no stale data
    end
  endtask
endmodule

// ### tb/pcrbm_top_bench.sv
// pcrbm_top_bench.sv: self-checking bench for pcrbm_top
// assumes the checker binds itself to the top
`timescale 1ns/10ps
module pcrbm_top_bench;
  reg         mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  reg  [2:0]  ev = 3'h0;
  reg  [3:0]  sel = 4'h0;
  reg  [31:0] wd = 32'h0;
  reg  [67:0] rows [0:7];
  wire        rv, en, b5en, drop, lwr;
  wire [3:0]  lsel;
  wire [31:0] rdat, b5m, lwd;
  int         failures = 0, total_checks = 0, i;
  always #2.5 mclk = ~mclk;
  pcrbm_top u_pcrbm_top (.i_mclk(mclk), .i_rst_n(rst_n), .i_hot_rst(ev[2]),
    .i_soft_rst(ev[1]), .i_hard_rst(ev[0]), .i_loc_wr(wr), .i_loc_rd(rd),
    .i_loc_sel(sel), .i_loc_wdata(wd), .o_loc_rdata(rdat), .o_loc_rvalid(rv),
    .i_lnk_wr(lwr), .i_lnk_sel(lsel), .i_lnk_wdata(lwd),
    .o_mask_access_enable_bit(en), .o_bar5_enabled(b5en), .o_bar5_mask(b5m),
    .o_mask_wr_dropped(drop));
  pcrbm_link_model u_pcrbm_link_model (.i_mclk(mclk), .o_wr(lwr), .o_sel(lsel),
    .o_wdata(lwd));
  ////////////////////////////////////////
  task stop_test;
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr_w(input [3:0] s, input [31:0] d);
    @(negedge mclk) {wr, sel, wd} = {1'b1, s, d};
    @(negedge mclk) wr = 1'b0;
  endtask
  // read data and valid stand one cycle after the strobe
  task rd_c(input [3:0] s, input [31:0] e);
    @(negedge mclk) {rd, sel} = {1'b1, s};
    @(negedge mclk) rd = 1'b0;
    chk("rvalid", 1, rv);
    chk("rdata", e, rdat);
  endtask
  task pulse(input [2:0] v);
    @(negedge mclk) ev = v;
    @(negedge mclk) ev = 3'h0;
    repeat (2) @(negedge mclk);
  endtask
  ////////////////////////////////////////
  initial begin
    #20000 failures++;
    stop_test;
  end
  initial begin
    rows[0] = {4'h1, 32'hdead_beef, 32'hdead_beef};
    rows[1] = {4'h2, 32'h1234_5678, 32'h1234_5678};
    rows[2] = {4'hd, 32'hffff_0000, 32'h0};
    rows[3] = {4'h0, 32'h20, 32'h20};
    rows[4] = {4'hd, 32'hfff0_0000, 32'hfff0_0000};
    rows[5] = {4'h8, 32'hffff_f000, 32'hffff_f000};
    rows[6] = {4'h0, 32'h0, 32'h0};
    rows[7] = {4'hd, 32'h1, 32'hfff0_0000};
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    for (i = 0; i < 8; i++) begin
      wr_w(rows[i][67:64], rows[i][63:32]);
      rd_c(rows[i][67:64], rows[i][31:0]);
    end
    chk("bar5_mask", 32'hfff0_0000, b5m);
    chk("bar5_en", 1, b5en);
    pulse(3'h4);
    rd_c(4'h1, 32'hdead_beef);
    chk("bar5_en", 0, b5en);
    wr_w(4'h2, 32'h1234_5678);
    wr_w(4'h0, 32'h20);
    wr_w(4'hd, 32'h0f00_0000);
    @(negedge mclk) chk("bar5_en", 1, b5en);
    pulse(3'h2);
    rd_c(4'h1, 32'hdead_beef);
    rd_c(4'h2, 32'h0);
    chk("bar5_mask", 0, b5m);
    chk("enable", 0, en);
    u_pcrbm_link_model.send(4'h0, 32'h20);
    u_pcrbm_link_model.send(4'hd, 32'hffff_ffff);
    chk("dropped", 1, drop);
    chk("enable", 1, en);
    wr_w(4'hd, 32'hff00_0000);
    rd_c(4'hd, 32'hff00_0000);
    @(negedge mclk) chk("rvalid", 0, rv);
    pulse(3'h1);
    rd_c(4'h1, 32'h0);
    chk("bar5_mask", 0, b5m);
    stop_test;
  end
endmodule
